// ### rtl/hmsp_host_port.sv
/*
  Host mode select and byte-oriented serial control slave port.
  Assumes: host is the serial master, its clock idles low and is far slower
  than clk_sys (at least four system clocks per clock phase); the attention
  line has an external pull-up; a core on clk_sys consumes and supplies bytes.
*/
// What this block does
// - mode strap pins are sampled as reset is released, choosing the host interface
// - 111 parallel A, 110 parallel B, 01x two-wire, 10x serial port
// - only one host mode is ever active; serial engine runs only in its mode
// - serial port uses select, clock, data in, data out and attention lines
// - write data accepted only after an address byte of 0x00
// - each received byte goes to the core on the eighth clock fall
// - a write may carry any number of bytes with the same framing
// - attention driven low while outgoing data is waiting and a read request is armed
// - read data offered only after an address byte of 0x01
// - read data changes on falling edges, valid on rising edges
// - attention rises at the second-to-last bit rise of the final byte
// - after rising, attention stays high at least to the next clock rise
// - attention output only pulls low, never drives high
// - attention stays high until the core reports a new read request
`timescale 1ns/100ps
`default_nettype none

module hmsp_host_port (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic readStrobePin,
  input wire logic storeStrobePin,
  input wire logic styleSelectPin,
  input wire logic portSelect_n,
  input wire logic serial_control_clock,
  input wire logic control_serial_in,
  output logic control_serial_out,
  output logic host_attention_n_out,
  output logic host_attention_n_oe,
  output logic [1:0] hostMode,
  output logic hostModeValid,
  output logic [7:0] rxData,
  output logic rxValid,
  input wire logic [7:0] txData,
  input wire logic txValid,
  output logic txReady,
  input wire logic readRequest
);

  // ----------------------------------------------------------------------
  // state record
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [hmsp_pkg::PIN_W-1:0] sync1;
    logic [hmsp_pkg::PIN_W-1:0] sync2;
    logic [hmsp_pkg::PIN_W-1:0] prev;
    logic [1:0] settle;
    logic modeValid;
    hmsp_pkg::hmsp_mode_t mode;
    hmsp_pkg::hmsp_phase_t phase;
    logic [2:0] bitCnt;
    logic [7:0] shIn;
    logic [7:0] shOut;
    logic dout;
    logic [7:0] rxData;
    logic rxValid;
    logic [7:0] txHold;
    logic holdFull;
    logic armed;
    logic attnLow;
    logic holdHigh;
    logic txFree;
  } hmsp_state_t;

  hmsp_state_t st_q;
  hmsp_state_t st_d;

  logic sclkRise;
  logic sclkFall;
  logic selActive;
  logic spiOn;
  logic [7:0] byteIn;
  hmsp_pkg::hmsp_mode_t strapMode;

  // ----------------------------------------------------------------------
  // edge detection works on synchronised copies only
  // ----------------------------------------------------------------------
  // prev is one more delay of sync2, so sync1 feeds nothing but sync2
  assign sclkRise = st_q.sync2[hmsp_pkg::PIN_SCLK] & ~st_q.prev[hmsp_pkg::PIN_SCLK];
  assign sclkFall = ~st_q.sync2[hmsp_pkg::PIN_SCLK] & st_q.prev[hmsp_pkg::PIN_SCLK];
  assign selActive = ~st_q.sync2[hmsp_pkg::PIN_SEL_N];
  assign spiOn = st_q.modeValid && (st_q.mode == hmsp_pkg::MODE_SPI);
  // byte as it stands after eight rises, before the falling edge is taken
  assign byteIn = st_q.shIn;

  // strap decode; an illegal 00x is read as two-wire since read low wins
  always_comb begin
    if (!st_q.sync2[hmsp_pkg::PIN_READ]) begin
      strapMode = hmsp_pkg::MODE_TWO_WIRE;
    end else if (!st_q.sync2[hmsp_pkg::PIN_STORE]) begin
      strapMode = hmsp_pkg::MODE_SPI;
    end else if (st_q.sync2[hmsp_pkg::PIN_STYLE]) begin
      strapMode = hmsp_pkg::MODE_PAR_A;
    end else begin
      strapMode = hmsp_pkg::MODE_PAR_B;
    end
  end

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    st_d.sync1 = {styleSelectPin, storeStrobePin, readStrobePin,
                  control_serial_in, portSelect_n, serial_control_clock};
    st_d.sync2 = st_q.sync1;
    st_d.prev = st_q.sync2;
    st_d.rxValid = 1'b0;

    // mode capture once, just after release, then frozen until reset
    if (!st_q.modeValid) begin
      if (st_q.settle == hmsp_pkg::STRAP_SETTLE) begin
        st_d.mode = strapMode;
        st_d.modeValid = 1'b1;
      end else begin
        st_d.settle = st_q.settle + 2'h1;
      end
    end

    // core hands over outgoing bytes through a single holding register
    if (txValid && !st_q.holdFull) begin
      st_d.txHold = txData;
      st_d.holdFull = 1'b1;
    end

    // a new read request message re-arms the attention line
    if (readRequest) begin
      st_d.armed = 1'b1;
    end

    // attention goes low only when armed and a byte waits; never inside the
    // hold-off after a release, so the host always sees a clean high level
    if (st_q.armed && st_q.holdFull && spiOn && !st_q.holdHigh) begin
      st_d.attnLow = 1'b1;
    end

    // the serial engine is alive only in its own mode
    if (!spiOn || !selActive) begin
      // select high ends the frame; any partial byte is dropped
      st_d.phase = hmsp_pkg::PH_ADDR;
      st_d.bitCnt = 3'h0;
      st_d.holdHigh = 1'b0;
    end else begin
      if (sclkRise) begin
        st_d.holdHigh = 1'b0;
        st_d.shIn = {st_q.shIn[6:0], st_q.sync2[hmsp_pkg::PIN_DIN]};
        // release attention at the second-to-last bit of the final byte
        if (st_q.phase == hmsp_pkg::PH_READ &&
            st_q.bitCnt == hmsp_pkg::NEXT_TO_LAST_BIT &&
            !st_q.holdFull && st_q.attnLow) begin
          st_d.attnLow = 1'b0;
          st_d.armed = readRequest;
          st_d.holdHigh = 1'b1;
        end
      end
      if (sclkFall) begin
        st_d.bitCnt = st_q.bitCnt + 3'h1;
        // outgoing bits move only on falling edges
        if (st_q.phase == hmsp_pkg::PH_READ) begin
          st_d.dout = st_q.shOut[6];
          st_d.shOut = {st_q.shOut[6:0], 1'b0};
        end
        if (st_q.bitCnt == hmsp_pkg::LAST_BIT) begin
          case (st_q.phase)
            hmsp_pkg::PH_ADDR: begin
              if (byteIn == hmsp_pkg::ADDR_WRITE) begin
                st_d.phase = hmsp_pkg::PH_WRITE;
              end else if (byteIn == hmsp_pkg::ADDR_READ) begin
                st_d.phase = hmsp_pkg::PH_READ;
              end else begin
                st_d.phase = hmsp_pkg::PH_IGNORE;
              end
            end
            hmsp_pkg::PH_WRITE: begin
              st_d.rxData = byteIn;
              st_d.rxValid = 1'b1;
            end
            default: begin
            end
          endcase
          // at a byte boundary of a read, load the next byte (or ones filler)
          if ((st_q.phase == hmsp_pkg::PH_ADDR && byteIn == hmsp_pkg::ADDR_READ) ||
              st_q.phase == hmsp_pkg::PH_READ) begin
            if (st_q.holdFull) begin
              st_d.dout = st_q.txHold[7];
              st_d.shOut = st_q.txHold;
              st_d.holdFull = 1'b0;
            end else begin
              st_d.dout = 1'b1;
              st_d.shOut = 8'hFF;
            end
          end
        end
      end
    end

    // registered so txReady leaves a flip-flop rather than an inverter
    st_d.txFree = !st_d.holdFull;
  end

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  // async reset loads constants only; straps are caught later by settle
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      st_q <= '0;
      st_q.mode <= hmsp_pkg::MODE_PAR_A;
      st_q.phase <= hmsp_pkg::PH_ADDR;
      st_q.dout <= 1'b1;
      st_q.txFree <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  // ----------------------------------------------------------------------
  // outputs, all from flip-flops except the constant-low attention drive
  // ----------------------------------------------------------------------
  // the attention pin only ever pulls low; the pull-up makes the high
  assign host_attention_n_out = 1'b0;
  assign host_attention_n_oe = st_q.attnLow;
  assign control_serial_out = st_q.dout;
  assign hostMode = st_q.mode;
  assign hostModeValid = st_q.modeValid;
  assign rxData = st_q.rxData;
  assign rxValid = st_q.rxValid;
  assign txReady = st_q.txFree;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!arst_n);

  chk_mode_decode: assert property (
    $rose(st_q.modeValid) |-> st_q.mode == $past(strapMode))
    else $error("latched mode differs from strap decode");

  chk_mode_frozen: assert property (
    $past(st_q.modeValid) |-> st_q.modeValid && $stable(st_q.mode))
    else $error("host mode changed while running");

  chk_mode_single: assert property (
    st_q.phase != hmsp_pkg::PH_ADDR |-> st_q.mode == hmsp_pkg::MODE_SPI)
    else $error("serial engine active outside its mode");

  chk_write_addr: assert property (
    $rose(st_q.phase == hmsp_pkg::PH_WRITE) |-> $past(byteIn) == hmsp_pkg::ADDR_WRITE)
    else $error("write phase entered without write address");

  chk_read_addr: assert property (
    $rose(st_q.phase == hmsp_pkg::PH_READ) |-> $past(byteIn) == hmsp_pkg::ADDR_READ)
    else $error("read phase entered without read address");

  chk_rx_timing: assert property (
    rxValid |-> $past(sclkFall && st_q.bitCnt == hmsp_pkg::LAST_BIT &&
                      st_q.phase == hmsp_pkg::PH_WRITE && selActive))
    else $error("byte delivered away from the eighth falling edge");

  chk_dout_edge: assert property (
    $changed(st_q.dout) && $past(st_q.modeValid) |-> $past(sclkFall))
    else $error("serial out changed off a falling edge");

  chk_attn_release: assert property (
    $fell(st_q.attnLow) |-> $past(sclkRise && st_q.bitCnt == hmsp_pkg::NEXT_TO_LAST_BIT))
    else $error("attention released at the wrong bit");

  chk_attn_rearm: assert property (
    $rose(st_q.attnLow) |-> $past(st_q.armed && st_q.holdFull))
    else $error("attention asserted without request and data");

  chk_attn_hold: assert property (
    st_q.holdHigh |-> !st_q.attnLow)
    else $error("attention pulled low again before the next clock rise");

  chk_rx_pulse: assert property (
    rxValid |=> !rxValid)
    else $error("received byte strobe longer than one cycle");

  cov_write_byte: cover property (rxValid);
  cov_read_end: cover property ($fell(st_q.attnLow));
  cov_attn_low: cover property ($rose(st_q.attnLow));
  cov_spi_mode: cover property ($rose(st_q.modeValid) ##1 spiOn);

endmodule

`default_nettype wire

// ### rtl/hmsp_pkg.sv
/*
  Constants and types shared by the host mode select and serial control port.
  Assumes a single 100 MHz system clock; all pins arrive asynchronously.
*/
`default_nettype none

package hmsp_pkg;

  // ----------------------------------------------------------------------
  // host interface modes, gray coded
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_PAR_A    = 2'h0,
    MODE_PAR_B    = 2'h1,
    MODE_TWO_WIRE = 2'h3,
    MODE_SPI      = 2'h2
  } hmsp_mode_t;

  // ----------------------------------------------------------------------
  // serial transaction phase, gray coded along address -> write / ignore
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    PH_ADDR   = 2'h0,
    PH_WRITE  = 2'h1,
    PH_READ   = 2'h3,
    PH_IGNORE = 2'h2
  } hmsp_phase_t;

  // ----------------------------------------------------------------------
  // byte framing and address bytes
  // ----------------------------------------------------------------------
  localparam int unsigned BYTE_W = 8;
  localparam logic [7:0] ADDR_WRITE = 8'h00;
  localparam logic [7:0] ADDR_READ = 8'h01;
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam logic [2:0] NEXT_TO_LAST_BIT = 3'h6;

  // ----------------------------------------------------------------------
  // pin vector layout for the input synchroniser
  // ----------------------------------------------------------------------
  localparam int unsigned PIN_W = 6;
  localparam int unsigned PIN_SCLK = 0;
  localparam int unsigned PIN_SEL_N = 1;
  localparam int unsigned PIN_DIN = 2;
  localparam int unsigned PIN_READ = 3;
  localparam int unsigned PIN_STORE = 4;
  localparam int unsigned PIN_STYLE = 5;

  // cycles after reset release before straps are trusted (sync depth + 1)
  localparam logic [1:0] STRAP_SETTLE = 2'h3;

endpackage

`default_nettype wire

// ### sim/hmsp_host_model.sv
/*
  Host master model for the serial control port: select, clock and data in.
  Assumes the caller sequences frames; clock period 160 ns, idle low.
*/
`timescale 1ns/100ps
`default_nettype none

module hmsp_host_model (
  output logic portSelect_n,
  output logic serial_control_clock,
  output logic control_serial_in,
  input wire logic control_serial_out,
  input wire logic attention
);
  // ----------------------------------------------------------------------
  // idle state: deselected, clock parked low
  // ----------------------------------------------------------------------
  initial begin
    portSelect_n = 1'b1;
    serial_control_clock = 1'b0;
    control_serial_in = 1'b0;
  end

  // open a frame by pulling select low
  task automatic start();
    portSelect_n = 1'b0;
    #80;
  endtask

  // one byte, msb first; attention is sampled late in the 7th high phase
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx, output logic a7);
    for (int i = 7; i >= 0; i--) begin
      control_serial_in = tx[i];
      #80;
      rx[i] = control_serial_out;
      serial_control_clock = 1'b1;
      #70;
      if (i == 1) begin
        a7 = attention;
      end
      #10;
      serial_control_clock = 1'b0;
    end
  endtask

  // close only after the last fall; released data toggles so no stale level
  task automatic stop();
    #80;
    portSelect_n = 1'b1;
    control_serial_in = ~control_serial_in;
    #80;
  endtask
endmodule

`default_nettype wire

// ### sim/testbench.sv
/*
  Self-checking bench: mode straps, write frames and a two-byte read.
  Assumes the host model drives the serial pins; attention has a pull-up.
*/
`timescale 1ns/100ps
`default_nettype none

module testbench;
  logic clk_sys = 1'b0;
  logic arst_n = 1'b0;
  logic readStrobePin = 1'b1, storeStrobePin = 1'b0, styleSelectPin = 1'b0;
  logic portSelect_n, serial_control_clock, control_serial_in;
  logic control_serial_out, host_attention_n_out, host_attention_n_oe;
  logic [1:0] hostMode;
  logic hostModeValid, rxValid, txReady, txValid = 1'b0, readRequest = 1'b0;
  logic [7:0] rxData, txData = 8'h00, r;
  logic a, attn;
  logic [7:0] rxq[$];
  logic [4:0] rows [6] = '{5'h1C, 5'h19, 5'h0B, 5'h0F, 5'h16, 5'h12};
  int n_fail = 0, compares = 0, cycles = 0;

  always #5 clk_sys = ~clk_sys;
  // pull-up: the line is high unless the port pulls it down
  assign attn = host_attention_n_oe ? host_attention_n_out : 1'b1;

  hmsp_host_port hmsp_host_port_inst (.clk_sys(clk_sys), .arst_n(arst_n),
    .readStrobePin(readStrobePin), .storeStrobePin(storeStrobePin),
    .styleSelectPin(styleSelectPin), .portSelect_n(portSelect_n),
    .serial_control_clock(serial_control_clock), .control_serial_in(control_serial_in),
    .control_serial_out(control_serial_out), .host_attention_n_out(host_attention_n_out),
    .host_attention_n_oe(host_attention_n_oe), .hostMode(hostMode),
    .hostModeValid(hostModeValid), .rxData(rxData), .rxValid(rxValid), .txData(txData),
    .txValid(txValid), .txReady(txReady), .readRequest(readRequest));

  hmsp_host_model hmsp_host_model_inst (.portSelect_n(portSelect_n),
    .serial_control_clock(serial_control_clock), .control_serial_in(control_serial_in),
    .control_serial_out(control_serial_out), .attention(attn));

  // collect delivered bytes; a one-cycle pulse must not be missed
  always @(posedge clk_sys) begin
    if (rxValid === 1'b1) rxq.push_back(rxData);
    cycles <= cycles + 1;
    if (cycles == 8000) begin
      n_fail++;
      report_and_stop();
    end
  end

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask

  task automatic report_and_stop();
    if (n_fail == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // in rst, straps change while reset is held, at the falling edge
  task automatic rst(input logic [2:0] s);
    @(negedge clk_sys);
    arst_n = 1'b0;
    {readStrobePin, storeStrobePin, styleSelectPin} = s;
    repeat (20) @(negedge clk_sys);
    arst_n = 1'b1;
    repeat (8) @(negedge clk_sys);
  endtask

  // core offers one byte and holds it until taken
  task automatic offer(input logic [7:0] b);
    @(negedge clk_sys);
    txData = b;
    txValid = 1'b1;
    while (txReady !== 1'b1) @(negedge clk_sys);
    @(negedge clk_sys);
    txValid = 1'b0;
  endtask

  // three-byte frame then the count of delivered bytes
  task automatic frame(input logic [7:0] b0, b1, b2, input logic [7:0] n);
    rxq.delete();
    hmsp_host_model_inst.start();
    hmsp_host_model_inst.xfer(b0, r, a);
    hmsp_host_model_inst.xfer(b1, r, a);
    hmsp_host_model_inst.xfer(b2, r, a);
    hmsp_host_model_inst.stop();
    repeat (10) @(negedge clk_sys);
    chk("rxCount", n, 8'(rxq.size()));
  endtask

  initial begin
    repeat (20) @(negedge clk_sys);
    chk("rstOut", 8'h09, {4'h0, control_serial_out, host_attention_n_oe, hostModeValid,
      txReady});
    // strap table rows: read, store, style, expected mode
    foreach (rows[i]) begin
      rst(rows[i][4:2]);
      chk("mode", {6'h00, rows[i][1:0]}, {6'h00, hostMode});
      chk("modeValid", 8'h01, {7'h00, hostModeValid});
      {readStrobePin, storeStrobePin, styleSelectPin} = ~rows[i][4:2];
      repeat (10) @(negedge clk_sys);
      chk("modeHeld", {6'h00, rows[i][1:0]}, {6'h00, hostMode});
    end
    // parallel mode ignores serial traffic; serial mode takes write bytes and ignores an unknown address
    rst(3'h7);
    frame(8'h00, 8'hA5, 8'h3C, 8'h00);
    rst(3'h4);
    frame(8'h00, 8'hA5, 8'h3C, 8'h02);
    chk("rx0", 8'hA5, rxq[0]);
    chk("rx1", 8'h3C, rxq[1]);
    frame(8'h05, 8'h77, 8'h11, 8'h00);
    // data held but no request: attention stays released; a request then pulls it low for a two-byte read
    offer(8'hC3);
    repeat (6) @(negedge clk_sys);
    chk("attnIdle", 8'h01, {7'h00, attn});
    readRequest = 1'b1;
    @(negedge clk_sys);
    readRequest = 1'b0;
    repeat (5) @(negedge clk_sys);
    chk("attnLow", 8'h00, {7'h00, attn});
    hmsp_host_model_inst.start();
    hmsp_host_model_inst.xfer(8'h01, r, a);
    offer(8'h5A);
    hmsp_host_model_inst.xfer(8'hFF, r, a);
    chk("rd0", 8'hC3, r);
    chk("attnMid", 8'h00, {7'h00, a});
    hmsp_host_model_inst.xfer(8'hFF, r, a);
    chk("rd1", 8'h5A, r);
    chk("attnEnd", 8'h01, {7'h00, a});
    hmsp_host_model_inst.stop();
    repeat (10) @(negedge clk_sys);
    chk("attnAfter", 8'h01, {7'h00, attn});
    // request with nothing held: no attention, and a read yields filler ones
    readRequest = 1'b1;
    @(negedge clk_sys);
    readRequest = 1'b0;
    repeat (5) @(negedge clk_sys);
    chk("attnEmpty", 8'h01, {7'h00, attn});
    hmsp_host_model_inst.start();
    hmsp_host_model_inst.xfer(8'h01, r, a);
    hmsp_host_model_inst.xfer(8'hFF, r, a);
    hmsp_host_model_inst.stop();
    chk("rdFill", 8'hFF, r);
    // the request stays armed, so a byte offered now pulls attention low
    offer(8'h96);
    repeat (5) @(negedge clk_sys);
    chk("attnRearm", 8'h00, {7'h00, attn});
    report_and_stop();
  end
endmodule

`default_nettype wire
